// *** include/hswc_defs.vh ***
// Constants for the halt / clock stop wake controller.
// Assumes a single 100 MHz clock; included by bare name.
`ifndef HSWC_DEFS_VH
`define HSWC_DEFS_VH

// ------------------------------------------------------------
// Wake operand bit positions (halt and stop share the layout)
// ------------------------------------------------------------
`define HSWC_SEL_PORT      0
`define HSWC_SEL_TIMER     1
`define HSWC_SEL_RSVD      2
`define HSWC_SEL_IRQ       3
`define HSWC_SEL_USED_MASK 4'hb

// ------------------------------------------------------------
// Controller states
// ------------------------------------------------------------
`define HSWC_ST_RUN        2'h0
`define HSWC_ST_HALT       2'h1
`define HSWC_ST_STOP       2'h2
`define HSWC_ST_SETTLE     2'h3

// ------------------------------------------------------------
// Wake cause codes, one-hot: port, timer, interrupt
// ------------------------------------------------------------
`define HSWC_CAUSE_NONE    3'h0
`define HSWC_CAUSE_PORT    3'h1
`define HSWC_CAUSE_TIMER   3'h2
`define HSWC_CAUSE_IRQ     3'h4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define HSWC_RST_SEL       4'h0
`define HSWC_RST_VEC       4'h0

// ------------------------------------------------------------
// Timing: clock period and settle prescaler tick
// ------------------------------------------------------------
`define HSWC_CLK_PERIOD_NS 10
`define HSWC_TICK_US       10
`define HSWC_TICK_CYC      ((`HSWC_TICK_US * 1000) / `HSWC_CLK_PERIOD_NS)
// Settling times in prescaler ticks per clock selection
`define HSWC_TSET0_TICKS   16
`define HSWC_TSET1_TICKS   32
`define HSWC_TSET2_TICKS   64
`define HSWC_TSET3_TICKS   128

`endif

// *** design/hswc_wake_eval.v ***
// Combinational wake evaluation for halt and clock stop.
// Assumes request/permit flags and port levels are synchronous.
`timescale 1ns/1ps
`include "hswc_defs.vh"

module hswc_wake_eval #(
   parameter NIRQ = 12
) (
   // Selection and mode
   input  wire [3:0]      sel_in,
   input  wire            stop_mode_in,
   // Sources
   input  wire [3:0]      wake_port_inputs_in,
   input  wire [3:0]      port_adc_mode_in,
   input  wire            base_timer_carry_flag_in,
   input  wire [NIRQ-1:0] irq_request_flag_in,
   input  wire [NIRQ-1:0] irq_permit_flag_in,
   input  wire            global_irq_on_in,
   // Results
   output reg             wake_out,
   output reg  [2:0]      cause_out,
   output reg             irq_take_out,
   output reg  [3:0]      vec_idx_out
);

   // ---------------------------------------------------------
   // Per-source pending: request and permit both set
   // ---------------------------------------------------------
   wire [NIRQ-1:0] pend;
   genvar g;
   generate
      for (g = 0; g < NIRQ; g = g + 1) begin : g_pend
         assign pend[g] = irq_request_flag_in[g] & irq_permit_flag_in[g];
      end
   endgenerate

   // ---------------------------------------------------------
   // Source hits and priority pick (lowest index wins)
   // ---------------------------------------------------------
   reg port_hit;
   reg tmr_hit;
   reg irq_hit;
   integer i;
   always @* begin
      // Pins on the converter never wake the core
      port_hit = sel_in[`HSWC_SEL_PORT] &
                 (|(wake_port_inputs_in & ~port_adc_mode_in));
      tmr_hit  = sel_in[`HSWC_SEL_TIMER] & base_timer_carry_flag_in;
      // Stop ignores the global enable; halt needs acceptance
      irq_hit  = sel_in[`HSWC_SEL_IRQ] & (|pend) &
                 (stop_mode_in | global_irq_on_in);
      // Any one selected source suffices
      wake_out = port_hit | tmr_hit | irq_hit;
      cause_out = {irq_hit, tmr_hit, port_hit};
      // Only a halt wake branches to a vector
      irq_take_out = irq_hit & ~stop_mode_in;
      vec_idx_out  = `HSWC_RST_VEC;
      for (i = NIRQ - 1; i >= 0; i = i - 1) begin
         if (pend[i]) begin
            vec_idx_out = i[3:0];
         end
      end
   end

endmodule

// *** design/hswc_settle_timer.v ***
// Post-stop settling wait: prescaler plus tick counter.
// Assumes start is a one-cycle pulse while the timer is idle.
`timescale 1ns/1ps
`include "hswc_defs.vh"

module hswc_settle_timer #(
   parameter        TICK_CYC = `HSWC_TICK_CYC,
   parameter [15:0] TSET0    = `HSWC_TSET0_TICKS,
   parameter [15:0] TSET1    = `HSWC_TSET1_TICKS,
   parameter [15:0] TSET2    = `HSWC_TSET2_TICKS,
   parameter [15:0] TSET3    = `HSWC_TSET3_TICKS
) (
   // Clock, reset, enable
   input  wire       clock_in,
   input  wire       sys_rst_in,
   input  wire       clk_en_in,
   // Control
   input  wire       start_in,
   input  wire [1:0] clk_sel_in,
   // Status
   output reg        done_out
);

   localparam [15:0] TICK_LAST = TICK_CYC[15:0] - 16'h0001;

   reg        busy;
   reg [15:0] pre_cnt;
   reg [15:0] tick_cnt;
   reg [15:0] target;
   reg [15:0] next_target;

   // ---------------------------------------------------------
   // Half of the selected settling time
   // ---------------------------------------------------------
   always @* begin
      case (clk_sel_in)
         2'h0:    next_target = {1'b0, TSET0[15:1]};
         2'h1:    next_target = {1'b0, TSET1[15:1]};
         2'h2:    next_target = {1'b0, TSET2[15:1]};
         default: next_target = {1'b0, TSET3[15:1]};
      endcase
   end

   // ---------------------------------------------------------
   // Count restarted oscillator through the prescaler
   // ---------------------------------------------------------
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         busy     <= 1'b0;
         pre_cnt  <= 16'h0000;
         tick_cnt <= 16'h0000;
         target   <= 16'h0000;
         done_out <= 1'b0;
      end else if (clk_en_in) begin
         done_out <= 1'b0;
         if (start_in) begin
            busy     <= 1'b1;
            pre_cnt  <= 16'h0000;
            tick_cnt <= 16'h0000;
            target   <= next_target;
         end else if (busy) begin
            if (pre_cnt == TICK_LAST) begin
               pre_cnt  <= 16'h0000;
               tick_cnt <= tick_cnt + 16'h0001;
            end else begin
               pre_cnt <= pre_cnt + 16'h0001;
            end
            // A zero target still waits one prescaler tick
            if ((pre_cnt == TICK_LAST) &&
                (tick_cnt + 16'h0001 >= target)) begin
               busy     <= 1'b0;
               done_out <= 1'b1;
            end
         end
      end
   end

endmodule

// *** design/hswc_core.v ***
// Halt and clock stop wake controller for a 4-bit core.
// Assumes the instruction sequencer issues one-cycle execute pulses
// and holds interrupt request and permit flags outside this block.
`timescale 1ns/1ps
`include "hswc_defs.vh"

module hswc_core #(
   parameter        NIRQ     = 12,
   parameter        TICK_CYC = `HSWC_TICK_CYC,
   parameter [15:0] TSET0    = `HSWC_TSET0_TICKS,
   parameter [15:0] TSET1    = `HSWC_TSET1_TICKS,
   parameter [15:0] TSET2    = `HSWC_TSET2_TICKS,
   parameter [15:0] TSET3    = `HSWC_TSET3_TICKS
) (
   // Clock, reset, enable
   input  wire            clock_in,
   input  wire            sys_rst_in,
   input  wire            clk_en_in,
   // Instruction sequencer requests
   input  wire            halt_exec_in,
   input  wire            stop_exec_in,
   input  wire [3:0]      operand_in,
   // Wake sources
   input  wire [3:0]      wake_port_inputs_in,
   input  wire [3:0]      port_adc_mode_in,
   input  wire            base_timer_carry_flag_in,
   input  wire [NIRQ-1:0] irq_request_flag_in,
   input  wire [NIRQ-1:0] irq_permit_flag_in,
   input  wire            global_irq_on_in,
   input  wire [1:0]      base_timer_clk_sel_in,
   // Reset sources that release stop, and chip-enable inputs that turn stop into a no-op
   input  wire            por_in,
   input  wire            ce_reset_in,
   input  wire            ce_pin_in,
   input  wire            ce_counter_running_in,
   // Power and clock control
   output reg             osc_enable_out,
   output reg             periph_clk_on_out,
   output reg             cpu_clk_on_out,
   output reg             pfd_enable_out,
   // State and events towards the sequencer
   output reg             halted_out,
   output reg             stopped_out,
   output reg             resume_out,
   output reg             irq_branch_out,
   output reg  [3:0]      irq_vector_idx_out,
   output reg  [2:0]      wake_cause_out,
   output reg             stop_as_nop_out,
   output reg             chip_enable_counter_active_flag_out
);

   // ---------------------------------------------------------
   // State and latched operand
   // ---------------------------------------------------------
   reg [1:0] state;
   reg [1:0] next_state;
   reg [3:0] wake_sel;
   reg [3:0] next_wake_sel;
   reg       ce_prev;

   // Wake evaluation results
   wire       wake_hit;
   wire [2:0] wake_cause;
   wire       wake_irq_take;
   wire [3:0] wake_vec;
   wire       settle_done;

   // Stop turns into a no-op at a chip-enable rise or counter run
   wire ce_rise  = ce_pin_in & ~ce_prev;
   wire stop_nop = ce_rise | ce_counter_running_in;

   // Reset sources that alone can end an all-zero stop
   wire stop_reset = por_in | ce_reset_in;

   // ---------------------------------------------------------
   // Wake evaluation; stop mode drops the global-enable term
   // ---------------------------------------------------------
   hswc_wake_eval #(
      .NIRQ(NIRQ)
   ) u_eval (
      .sel_in                   (wake_sel),
      .stop_mode_in             (state == `HSWC_ST_STOP),
      .wake_port_inputs_in      (wake_port_inputs_in),
      .port_adc_mode_in         (port_adc_mode_in),
      .base_timer_carry_flag_in (base_timer_carry_flag_in),
      .irq_request_flag_in      (irq_request_flag_in),
      .irq_permit_flag_in       (irq_permit_flag_in),
      .global_irq_on_in         (global_irq_on_in),
      .wake_out                 (wake_hit),
      .cause_out                (wake_cause),
      .irq_take_out             (wake_irq_take),
      .vec_idx_out              (wake_vec)
   );

   // ---------------------------------------------------------
   // Settling wait after a stop wake
   // ---------------------------------------------------------
   hswc_settle_timer #(
      .TICK_CYC (TICK_CYC),
      .TSET0    (TSET0),
      .TSET1    (TSET1),
      .TSET2    (TSET2),
      .TSET3    (TSET3)
   ) u_settle (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .clk_en_in  (clk_en_in),
      .start_in   ((state == `HSWC_ST_STOP) & wake_hit & ~stop_reset),
      .clk_sel_in (base_timer_clk_sel_in),
      .done_out   (settle_done)
   );

   // ---------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------
   always @* begin
      next_state    = state;
      next_wake_sel = wake_sel;
      case (state)
         `HSWC_ST_RUN: begin
            if (halt_exec_in) begin
               // Reserved bit 2 is dropped so it can never wake
               next_wake_sel = operand_in & `HSWC_SEL_USED_MASK;
               next_state    = `HSWC_ST_HALT;
            end else if (stop_exec_in && !stop_nop) begin
               // Reserved bit 2 is dropped here too; three operand bits are wake enables
               next_wake_sel = operand_in & `HSWC_SEL_USED_MASK;
               next_state    = `HSWC_ST_STOP;
            end
         end
         `HSWC_ST_HALT: begin
            // Flags are sampled live, so a request that is still set
            // after a late clear ends the halt on its first cycle
            if (wake_hit) begin
               next_state = `HSWC_ST_RUN;
            end
         end
         `HSWC_ST_STOP: begin
            // Zero operand never wakes; only resets leave
            if (stop_reset) begin
               next_state = `HSWC_ST_RUN;
            end else if (wake_hit) begin
               next_state = `HSWC_ST_SETTLE;
            end
         end
         default: begin
            if (stop_reset) begin
               next_state = `HSWC_ST_RUN;
            end else if (settle_done) begin
               next_state = `HSWC_ST_RUN;
            end
         end
      endcase
   end

   // ---------------------------------------------------------
   // State registers and chip-enable edge history
   // ---------------------------------------------------------
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         state    <= `HSWC_ST_RUN;
         wake_sel <= `HSWC_RST_SEL;
         ce_prev  <= 1'b0;
      end else if (clk_en_in) begin
         state    <= next_state;
         wake_sel <= next_wake_sel;
         ce_prev  <= ce_pin_in;
      end
   end

   // ---------------------------------------------------------
   // Clock and power controls, registered from the next state.
   // Peripherals keep their clock in halt; only the core pauses.
   // ---------------------------------------------------------
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         osc_enable_out    <= 1'b1;
         periph_clk_on_out <= 1'b1;
         cpu_clk_on_out    <= 1'b1;
         pfd_enable_out    <= 1'b1;
         halted_out        <= 1'b0;
         stopped_out       <= 1'b0;
      end else if (clk_en_in) begin
         // Oscillator runs again as soon as settling starts
         osc_enable_out    <= (next_state != `HSWC_ST_STOP);
         // No system clock for anyone while stopped or settling
         periph_clk_on_out <= (next_state == `HSWC_ST_RUN) |
                              (next_state == `HSWC_ST_HALT);
         cpu_clk_on_out    <= (next_state == `HSWC_ST_RUN);
         // Detector off so memory can be kept at low supply
         pfd_enable_out    <= (next_state != `HSWC_ST_STOP) &
                              (next_state != `HSWC_ST_SETTLE);
         halted_out        <= (next_state == `HSWC_ST_HALT) |
                              (next_state == `HSWC_ST_SETTLE);
         stopped_out       <= (next_state == `HSWC_ST_STOP) |
                              (next_state == `HSWC_ST_SETTLE);
      end
   end

   // ---------------------------------------------------------
   // Wake events and cause reporting towards the sequencer
   // ---------------------------------------------------------
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         resume_out         <= 1'b0;
         irq_branch_out     <= 1'b0;
         irq_vector_idx_out <= `HSWC_RST_VEC;
         wake_cause_out     <= `HSWC_CAUSE_NONE;
         stop_as_nop_out    <= 1'b0;
      end else if (clk_en_in) begin
         resume_out      <= 1'b0;
         irq_branch_out  <= 1'b0;
         stop_as_nop_out <= 1'b0;
         if (state == `HSWC_ST_RUN && !halt_exec_in &&
             stop_exec_in && stop_nop) begin
            // Treated as a plain no-op; the core just moves on
            stop_as_nop_out <= 1'b1;
         end
         if (state == `HSWC_ST_HALT && wake_hit) begin
            wake_cause_out <= wake_cause;
            if (wake_irq_take) begin
               // Accepted interrupt branches to its vector
               irq_branch_out     <= 1'b1;
               irq_vector_idx_out <= wake_vec;
            end else begin
               resume_out <= 1'b1;
            end
         end
         if (state == `HSWC_ST_STOP && wake_hit && !stop_reset) begin
            // Stop wake never branches; it resumes after settling
            wake_cause_out <= wake_cause;
         end
         if (state == `HSWC_ST_SETTLE && settle_done && !stop_reset) begin
            resume_out <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------
   // Chip-enable counter status, readable by software
   // ---------------------------------------------------------
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         chip_enable_counter_active_flag_out <= 1'b0;
      end else if (clk_en_in) begin
         chip_enable_counter_active_flag_out <=
            ce_counter_running_in;
      end
   end

endmodule

// *** sim/hswc_chk_sva.sv ***
// Checker for the halt / clock stop wake controller.
// Assumes it is bound to hswc_core and sees only its ports.
`timescale 1ns/1ps

module hswc_chk #(
   parameter NIRQ = 12
) (
   // Clock and reset
   input wire            clock_in,
   input wire            sys_rst_in,
   input wire            clk_en_in,
   // Requests and sources
   input wire            halt_exec_in,
   input wire            stop_exec_in,
   input wire [3:0]      operand_in,
   input wire [3:0]      wake_port_inputs_in,
   input wire [3:0]      port_adc_mode_in,
   input wire            base_timer_carry_flag_in,
   input wire [NIRQ-1:0] irq_request_flag_in,
   input wire [NIRQ-1:0] irq_permit_flag_in,
   input wire            global_irq_on_in,
   input wire            por_in,
   input wire            ce_reset_in,
   input wire            ce_pin_in,
   input wire            ce_counter_running_in,
   // Outputs watched
   input wire            osc_enable_out,
   input wire            periph_clk_on_out,
   input wire            cpu_clk_on_out,
   input wire            pfd_enable_out,
   input wire            halted_out,
   input wire            stopped_out,
   input wire            resume_out,
   input wire            irq_branch_out,
   input wire [2:0]      wake_cause_out,
   input wire            stop_as_nop_out,
   input wire            chip_enable_counter_active_flag_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   reg  [3:0] sel_q;
   wire       run  = !halted_out && !stopped_out;
   wire       hlt  = halted_out && !stopped_out;
   wire       stp  = stopped_out && !halted_out;
   wire       p_hit = |(wake_port_inputs_in & ~port_adc_mode_in);
   wire       i_hit = |(irq_request_flag_in & irq_permit_flag_in);
   wire       rst_ev = por_in || ce_reset_in;
   wire       go_stop = clk_en_in && run && stop_exec_in && !halt_exec_in
                        && !rst_ev;

   // Operand kept as the design should have latched it, bit 2 dropped
   always @(posedge clock_in) begin
      if (sys_rst_in)
         sel_q <= 4'h0;
      else if (clk_en_in && run && (halt_exec_in || stop_exec_in))
         sel_q <= operand_in & 4'hb;
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   AST_STOP_ENTRY: assert property (
      go_stop && !ce_counter_running_in && !ce_pin_in
      |=> stopped_out && !osc_enable_out) else $error("stop not entered");
   AST_STOP_CLOCKS: assert property (
      stp |-> !cpu_clk_on_out && !periph_clk_on_out)
      else $error("clock running in stop");
   AST_PFD_OFF: assert property (
      stopped_out |-> !pfd_enable_out) else $error("detector on in stop");
   AST_STOP_NOP: assert property (
      go_stop && ce_counter_running_in
      |=> stop_as_nop_out && !stopped_out) else $error("stop not a no-op");
   AST_CE_FLAG: assert property (
      clk_en_in |=> chip_enable_counter_active_flag_out
      == $past(ce_counter_running_in)) else $error("counter flag wrong");
   AST_HALT_PORT: assert property (
      clk_en_in && hlt && sel_q[0] && p_hit |=> !halted_out)
      else $error("port did not end halt");
   AST_HALT_TIMER: assert property (
      clk_en_in && hlt && sel_q[1] && base_timer_carry_flag_in
      |=> !halted_out && wake_cause_out[1]) else $error("carry wake");
   AST_HALT_IRQ: assert property (
      clk_en_in && hlt && sel_q[3] && global_irq_on_in && i_hit
      |=> irq_branch_out && !halted_out) else $error("irq halt wake");
   AST_STOP_IRQ: assert property (
      clk_en_in && stp && sel_q[3] && i_hit && !rst_ev
      |=> halted_out && osc_enable_out && wake_cause_out[2])
      else $error("irq stop wake");
   AST_ZERO_HOLD: assert property (
      stp && sel_q == 4'h0 && !rst_ev |=> stopped_out && !osc_enable_out)
      else $error("zero operand stop left");
   AST_RST_EXIT: assert property (
      clk_en_in && stopped_out && rst_ev |=> !stopped_out && !resume_out)
      else $error("reset did not end stop");
   AST_SETTLE_END: assert property (
      $fell(stopped_out) && !$past(rst_ev) |-> resume_out)
      else $error("no resume after settle");
endmodule

// *** sim/hswc_irq_model.sv ***
// Interrupt flag logic of the sequencer side, behavioural.
// Assumes set, clear and permit commands come from the bench.
`timescale 1ns/1ps

module hswc_irq_model #(
   parameter NIRQ    = 12,
   parameter CLR_DLY = 3
) (
   // Clock and reset
   input  wire            clock_in,
   input  wire            sys_rst_in,
   // Commands
   input  wire [NIRQ-1:0] set_in,
   input  wire [NIRQ-1:0] clr_in,
   input  wire [NIRQ-1:0] perm_in,
   // Flags
   output reg  [NIRQ-1:0] irq_request_flag_out,
   output wire [NIRQ-1:0] irq_permit_flag_out
);
   reg [NIRQ-1:0] pend;
   integer        cnt;

   assign irq_permit_flag_out = perm_in;

   // A clear lands CLR_DLY (three) cycles late, so a halt right after it wakes
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         irq_request_flag_out <= 'h0;
         pend <= 'h0;
         cnt <= 0;
      end else begin
         irq_request_flag_out <= irq_request_flag_out | set_in;
         if (|clr_in) begin
            pend <= clr_in;
            cnt <= CLR_DLY - 1;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end else if (|pend) begin
            irq_request_flag_out <= (irq_request_flag_out | set_in) & ~pend;
            pend <= 'h0;
         end
      end
   end
endmodule

// *** sim/test_halt_stop_wake_control.sv ***
// Self-checking bench for the halt / clock stop wake controller.
// Assumes hswc_core, hswc_irq_model and hswc_chk are compiled first.
`timescale 1ns/1ps

module test_halt_stop_wake_control;
   localparam TICK = 2; // Short prescaler keeps settle waits small
   logic clock_in = 0, sys_rst_in = 1, clk_en_in = 1;
   logic halt_exec_in = 0, stop_exec_in = 0, global_irq_on_in = 0;
   logic base_timer_carry_flag_in = 0, por_in = 0, ce_reset_in = 0;
   logic ce_pin_in = 0, ce_counter_running_in = 0;
   logic [3:0] operand_in = 0, wake_port_inputs_in = 0;
   logic [3:0] port_adc_mode_in = 0;
   logic [1:0] base_timer_clk_sel_in = 0;
   logic [11:0] set_r = 0, clr_r = 0, perm_r = 0;
   wire [11:0] irq_request_flag_in, irq_permit_flag_in;
   wire osc_enable_out, periph_clk_on_out, cpu_clk_on_out, pfd_enable_out;
   wire halted_out, stopped_out, resume_out, irq_branch_out;
   wire stop_as_nop_out, chip_enable_counter_active_flag_out;
   wire [3:0] irq_vector_idx_out;
   wire [2:0] wake_cause_out;
   int n_mismatch = 0, checks = 0, n;

   // ------------------------------------------------------------
   // Design, partner and clock
   // ------------------------------------------------------------
   hswc_core #(.TICK_CYC(TICK)) uut (.*);
   hswc_irq_model irq_m (.clock_in, .sys_rst_in, .set_in(set_r),
      .clr_in(clr_r), .perm_in(perm_r),
      .irq_request_flag_out(irq_request_flag_in),
      .irq_permit_flag_out(irq_permit_flag_in));
   initial forever #5 clock_in = ~clock_in;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task give_verdict;
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
         n_mismatch++;
      end
   endtask
   task tk(input int c);
      repeat (c) @(negedge clock_in);
   endtask
   task ex(input logic h, input logic s, input logic [3:0] op);
      halt_exec_in = h;
      stop_exec_in = s;
      operand_in = op;
      tk(1);
      halt_exec_in = 0;
      stop_exec_in = 0;
   endtask
   // Bounded wait on resume (0), branch (1) or halted (2)
   task wt(input int w, input int lim);
      n = 0;
      while ((w == 0 ? resume_out : w == 1 ? irq_branch_out : halted_out)
             !== 1'b1) begin
         tk(1);
         n++;
         if (n > lim) begin
            n_mismatch++;
            give_verdict;
         end
      end
   endtask
   task irq(input logic [11:0] s, input logic [11:0] c);
      set_r = s;
      clr_r = c;
      tk(1);
      set_r = 0;
      clr_r = 0;
   endtask
   // Settle length counted from wake to the resume pulse
   task settle(input int e);
      wt(0, e + 8);
      chk(n >= e && n <= e + 4, 1);
      chk({irq_branch_out, stopped_out, pfd_enable_out}, 3'b001);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task s_halt_timer;
      ex(1, 0, 4'h2);
      chk({halted_out, cpu_clk_on_out, periph_clk_on_out}, 3'b101);
      clk_en_in = 0;
      base_timer_carry_flag_in = 1;
      tk(3);
      chk(halted_out, 1);
      clk_en_in = 1;
      wt(0, 3);
      chk({halted_out, wake_cause_out}, 4'h2);
      base_timer_carry_flag_in = 0;
      tk(1);
   endtask
   task s_halt_port;
      perm_r = 12'h010;
      irq(12'h010, 0);
      port_adc_mode_in = 4'h4;
      wake_port_inputs_in = 4'h4;
      ex(1, 0, 4'hb);
      tk(4);
      chk(halted_out, 1);
      wake_port_inputs_in = 4'h5;
      wt(0, 3);
      chk({irq_branch_out, wake_cause_out}, 4'h1);
      wake_port_inputs_in = 0;
      irq(0, 12'h010);
      tk(4);
   endtask
   task s_halt_irq;
      global_irq_on_in = 1;
      perm_r = 12'h220;
      ex(1, 0, 4'h8);
      tk(2);
      chk(halted_out, 1);
      irq(12'h220, 0);
      wt(1, 4);
      chk({halted_out, irq_vector_idx_out, wake_cause_out}, 8'h2c);
      irq(0, 12'h220);
      tk(4);
   endtask
   task s_clear_halt;
      perm_r = 12'h008;
      irq(12'h008, 0);
      irq(0, 12'h008);
      ex(1, 0, 4'h8);
      wt(1, 3);
      chk(irq_vector_idx_out, 4'h3);
      tk(4);
   endtask
   task s_stop_irq;
      global_irq_on_in = 0;
      perm_r = 12'h080;
      ex(0, 1, 4'h8);
      chk({osc_enable_out, stopped_out, halted_out, pfd_enable_out,
           periph_clk_on_out, cpu_clk_on_out}, 6'h10);
      tk(3);
      irq(12'h080, 0);
      wt(2, 4);
      chk({osc_enable_out, stopped_out, wake_cause_out}, 5'h1c);
      settle(TICK * 8);
      irq(0, 12'h080);
      tk(4);
   endtask
   task s_stop_sel;
      for (int s = 0; s < 4; s++) begin
         base_timer_clk_sel_in = s[1:0];
         ex(0, 1, 4'h3);
         tk(2);
         base_timer_carry_flag_in = 1;
         wt(2, 4);
         base_timer_carry_flag_in = 0;
         chk(wake_cause_out[1], 1);
         settle(TICK * (8 << s));
      end
   endtask
   task s_stop_zero;
      for (int i = 0; i < 2; i++) begin
         ex(0, 1, 4'h0);
         wake_port_inputs_in = 4'hf;
         base_timer_carry_flag_in = 1;
         tk(4);
         chk({stopped_out, osc_enable_out}, 2'b10);
         wake_port_inputs_in = 0;
         base_timer_carry_flag_in = 0;
         por_in = (i == 0);
         ce_reset_in = (i == 1);
         tk(1);
         por_in = 0;
         ce_reset_in = 0;
         chk({stopped_out, resume_out, osc_enable_out}, 3'b001);
      end
   endtask
   task s_nop;
      ce_counter_running_in = 1;
      tk(1);
      chk(chip_enable_counter_active_flag_out, 1);
      ex(0, 1, 4'h1);
      chk({stop_as_nop_out, stopped_out}, 2'b10);
      ce_counter_running_in = 0;
      tk(1);
      chk(chip_enable_counter_active_flag_out, 0);
      ce_pin_in = 1;
      ex(0, 1, 4'h1);
      chk({stop_as_nop_out, stopped_out}, 2'b10);
      ce_pin_in = 0;
      tk(1);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      tk(5);
      sys_rst_in = 0;
      tk(1);
      chk({osc_enable_out, periph_clk_on_out, cpu_clk_on_out,
           pfd_enable_out, halted_out, stopped_out, resume_out,
           chip_enable_counter_active_flag_out}, 8'hf0);
      s_halt_timer;
      s_halt_port;
      s_halt_irq;
      s_clear_halt;
      s_stop_irq;
      s_stop_sel;
      s_stop_zero;
      s_nop;
      give_verdict;
   end
endmodule

bind hswc_core hswc_chk #(.NIRQ(NIRQ)) chk_i (.*);
